// ### src/aslseq_top.sv
// Acquisition start/stop, clock copy and 16-level sequential recognizer
// Assumes one 100 MHz MCLK; phase I and II are one-cycle enables on it;
// the qualify line arrives asynchronously and is synchronised here.
// Contract
// R1 - Qualify low forces all four qualifier outputs inactive
// R2 - Controller holds qualify low before acquisition, raises it to start
// R3 - Inverse of qualify registered each phase I edge; release one edge later
// R4 - Time-base board drops qualify after delay count, stopping acquisition
// R5 - Module init sets the start/stop flag, acquisition disabled
// R6 - Each enabled phase I rising edge yields one clock copy falling edge
// R7 - Clock copy runs while initialised but qualify still low
// R8 - After start, clock copy runs only while store-advance enable low
// R9 - Clock copy is a self-ending high pulse of 20 to 30 ns
// R10 - Low copy path enable holds clock copy outputs low
// R11 - Sixteen levels; 4-bit pointer addresses all three level memories
// R12 - Each recognizer memory: 4 pointer bits plus one data byte
// R13 - Match only when all three byte memories output one together
// R14 - Controller writes ones at every matching address, zeros elsewhere
// R15 - Controller preloads count complement; count of one is FFE
// R16 - Controller sets pointer 0 then strobes count load
// R17 - Occurrence counter is 12-bit up counter, one step per match
// R18 - At FFF advance pointer, reload new count on next phase II edge
// R19 - Match caught on phase II into self-clearing pulse; its end counts
// R20 - Controller loads per-level action memory
// R21 - Store address advances only while store-advance enable low
`timescale 1ns/10ps
`default_nettype none
`include "aslseq_regs.svh"
module aslseq_top
	import aslseq_pkg::*;
#(
	parameter int COPY_CYC = `ASL_COPY_CYC,
	parameter int MATCH_CYC = `ASL_MATCH_CYC
) (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic PHASE_ONE,
	input wire logic PHASE_TWO,
	input wire logic ACQ_QUALIFY,
	input wire logic MODULE_INIT,
	input wire logic STORE_ADVANCE_ENABLE_N,
	input wire logic COPY_PATH_ENABLE,
	input wire logic [`ASL_QUALS-1:0] QUAL_RAW,
	input wire logic [`ASL_DATA_W-1:0] ACQUIRED_DATA_BUS,
	input wire logic [`ASL_PTR_W-1:0] LEVEL_POINTER_SET,
	input wire logic LEVEL_POINTER_LOAD,
	input wire logic OCCURRENCE_COUNT_LOAD,
	input wire aslseq_wr_s MEM_WR,
	output logic [`ASL_QUALS-1:0] QUAL_OUT,
	output logic CLOCK_COPY,
	output logic [`ASL_PTR_W-1:0] LEVEL_POINTER,
	output logic [`ASL_CNT_W-1:0] OCCURRENCE_COUNT,
	output logic [3:0] LEVEL_ACTION,
	output logic SEQ_MATCH,
	output logic [15:0] STORE_ADDRESS
);
	localparam int NSEG = 1 << `ASL_MEM_AW;
	// Copy pulse must end before the next phase I; counters are 3 and 4 bits
	localparam bit BAD_CFG = COPY_CYC < 2 || COPY_CYC > 3
		|| MATCH_CYC < 1 || MATCH_CYC > 15;
	if (BAD_CFG) begin : g_bad_cfg
		$error("aslseq_top: pulse counts out of range");
	end

	logic q_s1, q_s2, stopped, n_s1, n_s2;
	logic [2:0] copy_cnt;
	logic [3:0] match_cnt;
	logic match_pulse;
	logic rec0 [NSEG];
	logic rec1 [NSEG];
	logic rec2 [NSEG];
	logic [`ASL_CNT_W-1:0] occ_mem [`ASL_LEVELS];
	logic [3:0] act_mem [`ASL_LEVELS];
	logic [`ASL_CNT_W-1:0] next_count;
	logic hit, copy_run, reload_pend;

	// Qualify and the store enable come from other boards
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			q_s1 <= 1'b0;
			q_s2 <= 1'b0;
			n_s1 <= 1'b1;
			n_s2 <= 1'b1;
		end else begin
			q_s1 <= ACQ_QUALIFY;
			q_s2 <= q_s1;
			n_s1 <= STORE_ADVANCE_ENABLE_N;
			n_s2 <= n_s1;
		end
	end

	// Start/stop flag holds the inverse of qualify; init forces it set
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST)
			stopped <= 1'b1;
		else if (MODULE_INIT)
			stopped <= 1'b1; // R5
		else if (PHASE_ONE)
			stopped <= ~q_s2; // R3 R4
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST)
			QUAL_OUT <= '0;
		else if (stopped)
			QUAL_OUT <= '0; // R1
		else
			QUAL_OUT <= QUAL_RAW;
	end

	assign copy_run = stopped | ~n_s2; // R7 R8

	// Counted pulse stands in for the RC one-shot
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			copy_cnt <= '0;
			CLOCK_COPY <= 1'b0;
		end else if (!COPY_PATH_ENABLE) begin
			copy_cnt <= '0; // R10
			CLOCK_COPY <= 1'b0; // R10
		end else if (PHASE_ONE && copy_run) begin
			copy_cnt <= 3'(COPY_CYC); // R9
			CLOCK_COPY <= 1'b1; // R6
		end else if (copy_cnt != '0) begin
			copy_cnt <= copy_cnt - 3'd1;
			CLOCK_COPY <= (copy_cnt != 3'd1);
		end
	end

	// Level memories, written by the controller before acquisition
	always_ff @(posedge MCLK) begin
		if (MEM_WR.we) begin
			unique case (MEM_WR.sel)
			2'd0: rec0[MEM_WR.addr] <= MEM_WR.data[0]; // R14
			2'd1: rec1[MEM_WR.addr] <= MEM_WR.data[0];
			2'd2: rec2[MEM_WR.addr] <= MEM_WR.data[0];
			2'd3: begin
				occ_mem[MEM_WR.addr[3:0]] <= MEM_WR.data; // R15
				act_mem[MEM_WR.addr[3:0]] <= MEM_WR.data[3:0]; // R20
			end
			endcase
		end
	end

	// One recognizer bit per 12-bit address: pointer segment plus data byte
	assign hit = rec0[{LEVEL_POINTER, ACQUIRED_DATA_BUS[7:0]}]
		& rec1[{LEVEL_POINTER, ACQUIRED_DATA_BUS[15:8]}]
		& rec2[{LEVEL_POINTER, ACQUIRED_DATA_BUS[23:16]}]; // R11 R12 R13

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST)
			SEQ_MATCH <= 1'b0;
		else
			SEQ_MATCH <= hit;
	end

	// Match pulse: set on phase II, self-clears after the set width
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			match_cnt <= '0;
			match_pulse <= 1'b0;
		end else if (PHASE_TWO && hit && !n_s2 && !match_pulse) begin
			match_cnt <= 4'(MATCH_CYC); // R19
			match_pulse <= 1'b1;
		end else if (match_cnt != '0) begin
			match_cnt <= match_cnt - 4'd1;
			match_pulse <= (match_cnt != 4'd1);
		end
	end

	always_comb begin
		next_count = OCCURRENCE_COUNT + 12'h001;
	end

	// Counter, pointer advance and reload; a load request outranks counting
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			OCCURRENCE_COUNT <= '0;
			LEVEL_POINTER <= '0;
			reload_pend <= 1'b0;
		end else if (LEVEL_POINTER_LOAD) begin
			LEVEL_POINTER <= LEVEL_POINTER_SET; // R16
			reload_pend <= 1'b0;
		end else if (OCCURRENCE_COUNT_LOAD) begin
			OCCURRENCE_COUNT <= occ_mem[LEVEL_POINTER]; // R16
			reload_pend <= 1'b0;
		end else if (reload_pend) begin
			if (PHASE_TWO) begin
				OCCURRENCE_COUNT <= occ_mem[LEVEL_POINTER]; // R18
				reload_pend <= 1'b0;
			end
		end else if (match_pulse && match_cnt == 4'd1) begin
			OCCURRENCE_COUNT <= next_count; // R17 R19
			if (next_count == `ASL_CNT_DONE) begin
				LEVEL_POINTER <= LEVEL_POINTER + 4'd1; // R18
				reload_pend <= 1'b1;
			end
		end
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST)
			LEVEL_ACTION <= '0;
		else
			LEVEL_ACTION <= act_mem[LEVEL_POINTER]; // R11
	end

	// Store address steps on phase I storage clock
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST)
			STORE_ADDRESS <= '0;
		else if (PHASE_ONE && !n_s2)
			STORE_ADDRESS <= STORE_ADDRESS + 16'h0001; // R21
	end

	a_qual_blocked: assert property (@(posedge MCLK) disable iff (RST) // R1
		$past(stopped) |-> QUAL_OUT == '0) else $error("qualifier not held");
	a_init_stops: assert property (@(posedge MCLK) disable iff (RST) // R5
		MODULE_INIT |=> stopped) else $error("init did not stop");
	a_start_edge: assert property (@(posedge MCLK) disable iff (RST) // R3
		PHASE_ONE && !MODULE_INIT && q_s2 |=> !stopped) else $error("no start");
	a_copy_gate: assert property (@(posedge MCLK) disable iff (RST) // R10
		!COPY_PATH_ENABLE |=> !CLOCK_COPY) else $error("copy not gated");
	a_copy_width: assert property (@(posedge MCLK) disable iff (RST) // R9
		$rose(CLOCK_COPY) && COPY_PATH_ENABLE |=> CLOCK_COPY)
		else $error("copy pulse short");
	a_copy_start: assert property (@(posedge MCLK) disable iff (RST) // R6
		PHASE_ONE && copy_run && COPY_PATH_ENABLE |=> CLOCK_COPY)
		else $error("copy not launched");
	a_ptr_step: assert property (@(posedge MCLK) disable iff (RST) // R18
		!LEVEL_POINTER_LOAD && !OCCURRENCE_COUNT_LOAD && !reload_pend
		&& match_pulse && match_cnt == 4'd1 && next_count == `ASL_CNT_DONE
		|=> LEVEL_POINTER == $past(LEVEL_POINTER) + 4'd1)
		else $error("pointer did not advance");
	a_addr_hold: assert property (@(posedge MCLK) disable iff (RST) // R21
		n_s2 |=> $stable(STORE_ADDRESS)) else $error("address moved");
endmodule // aslseq_top
`default_nettype wire

// ### inc/aslseq_regs.svh
// Timing counts and field constants for the acquisition start/level sequencer
// Assumes a 100 MHz MCLK; included by the package and the design file
`ifndef ASLSEQ_REGS_SVH
`define ASLSEQ_REGS_SVH
`define ASL_MCLK_NS 10
`define ASL_COPY_MIN_NS 20
`define ASL_COPY_MAX_NS 30
`define ASL_COPY_CYC ((`ASL_COPY_MIN_NS + `ASL_MCLK_NS - 1) / `ASL_MCLK_NS)
`define ASL_MATCH_PULSE_NS 30
`define ASL_MATCH_CYC (`ASL_MATCH_PULSE_NS / `ASL_MCLK_NS)
`define ASL_LEVELS 16
`define ASL_PTR_W 4
`define ASL_CNT_W 12
`define ASL_CNT_DONE 12'hfff
`define ASL_DATA_W 24
`define ASL_MEM_AW 12
`define ASL_QUALS 4
`endif

// ### inc/aslseq_pkg.sv
// Types shared by the acquisition start/level sequencer
// Assumes aslseq_regs.svh is on the include path
`include "aslseq_regs.svh"
package aslseq_pkg;
	typedef enum logic [1:0] {ASL_IDLE, ASL_RUN, ASL_RELOAD} aslseq_occ_e;
	// Host-side write port for the level memories; select 3 writes the count and action memories together
	typedef struct packed {
		logic we;
		logic [1:0] sel;
		logic [`ASL_MEM_AW-1:0] addr;
		logic [`ASL_CNT_W-1:0] data;
	} aslseq_wr_s;
endpackage

// ### verification/aslseq_ctl_model.sv
// Controller side of the qualify line: start and stop requests
// Assumes the bench pulses start_req and stop_req for one MCLK cycle
`timescale 1ns/10ps
`default_nettype none
module aslseq_ctl_model (
	input wire logic mclk,
	input wire logic rst,
	input wire logic start_req,
	input wire logic stop_req,
	output logic acq_qualify
);
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			acq_qualify <= 1'b0;
		else if (stop_req)
			acq_qualify <= 1'b0;
		else if (start_req)
			acq_qualify <= 1'b1;
	end
endmodule // aslseq_ctl_model
`default_nettype wire

// ### verification/testbench.sv
// Directed bench for the acquisition start/level sequencer
// Assumes phase I and II enables one cycle in four, two cycles apart
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import aslseq_pkg::*;
	logic mclk = 0, rst = 1, ph1 = 0, ph2 = 0, init = 0, sen_n = 1, cpe = 1;
	logic plod = 0, olod = 0, qual, start_r = 0, stop_r = 0, copy, match;
	logic [3:0] qraw = '0, pset = '0, qout, ptr, act;
	logic [23:0] dbus = 24'h5a3c81;
	logic [11:0] cnt;
	logic [15:0] saddr;
	logic [1:0] ph = '0;
	aslseq_wr_s wr = '0;
	int fails = 0, cmp_count = 0, cyc = 0, copies = 0;
	aslseq_ctl_model aslseq_ctl_model_i (.mclk(mclk), .rst(rst),
		.start_req(start_r), .stop_req(stop_r), .acq_qualify(qual));
	aslseq_top aslseq_top_i (.MCLK(mclk), .RST(rst), .PHASE_ONE(ph1),
		.PHASE_TWO(ph2), .ACQ_QUALIFY(qual), .MODULE_INIT(init),
		.STORE_ADVANCE_ENABLE_N(sen_n), .COPY_PATH_ENABLE(cpe),
		.QUAL_RAW(qraw), .ACQUIRED_DATA_BUS(dbus),
		.LEVEL_POINTER_SET(pset), .LEVEL_POINTER_LOAD(plod),
		.OCCURRENCE_COUNT_LOAD(olod), .MEM_WR(wr), .QUAL_OUT(qout),
		.CLOCK_COPY(copy), .LEVEL_POINTER(ptr), .OCCURRENCE_COUNT(cnt),
		.LEVEL_ACTION(act), .SEQ_MATCH(match), .STORE_ADDRESS(saddr));
	initial forever #5 mclk = ~mclk;
	always @(posedge mclk) begin
		ph <= ph + 2'h1;
		ph1 <= (ph == 2'h3);
		ph2 <= (ph == 2'h1);
		cyc <= cyc + 1;
		if (cyc > 5000) begin
			fails = fails + 1;
			close_out();
		end
	end
	always @(posedge copy) copies = copies + 1;
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wt(int n);
		repeat (n) @(posedge mclk);
	endtask
	// Window of 20 cycles holds exactly five phase I edges
	task automatic cnt_copies(string n, int e, logic [15:0] ea);
		logic [15:0] a0;
		@(negedge mclk) copies = 0;
		a0 = saddr;
		wt(20);
		@(negedge mclk) chk(n, e[15:0], copies[15:0]);
		chk({n, "_addr"}, ea, saddr - a0);
		@(posedge mclk);
	endtask
	task automatic wr_mem(logic [1:0] s, logic [11:0] a, logic [11:0] d);
		@(posedge mclk) wr <= '{1'b1, s, a, d};
		@(posedge mclk) wr.we <= 1'b0;
	endtask
	task automatic t_stopped;
		qraw <= 4'hf;
		init <= 1'b1;
		wt(4);
		init <= 1'b0;
		wt(8);
		chk("qual_stopped", 16'h0, {12'h0, qout});
		cnt_copies("copy_idle", 5, 16'h0);
		cpe <= 1'b0;
		wt(4);
		cnt_copies("copy_path_off", 0, 16'h0);
		cpe <= 1'b1;
	endtask
	task automatic t_setup;
		for (int i = 0; i < 3; i++) begin
			wr_mem(i[1:0], {4'h0, dbus[8*i+:8]}, 12'h001);
			wr_mem(i[1:0], {4'h1, dbus[8*i+:8]}, 12'h000);
		end
		wr_mem(2'h3, 12'h000, 12'hffe);
		wr_mem(2'h3, 12'h001, 12'hffd);
		@(posedge mclk) plod <= 1'b1;
		@(posedge mclk) plod <= 1'b0;
		olod <= 1'b1;
		@(posedge mclk) olod <= 1'b0;
		wt(2);
		chk("count_load", 16'h0ffe, {4'h0, cnt});
		chk("seq_match_l0", 16'h0001, {15'h0, match});
	endtask
	task automatic t_start;
		start_r <= 1'b1;
		@(posedge mclk) start_r <= 1'b0;
		wt(12);
		chk("qual_run", 16'h000f, {12'h0, qout});
		cnt_copies("copy_held", 0, 16'h0);
		chk("no_level_step", 16'h0, {12'h0, ptr});
		sen_n <= 1'b0;
		wt(4);
		cnt_copies("copy_store", 5, 16'h5);
		wt(20);
		chk("level_next", 16'h0001, {12'h0, ptr});
		chk("count_reload", 16'h0ffd, {4'h0, cnt});
		chk("level_action", 16'h000d, {12'h0, act});
		chk("seq_match_l1", 16'h0, {15'h0, match});
		stop_r <= 1'b1;
		@(posedge mclk) stop_r <= 1'b0;
		wt(12);
		chk("qual_after_stop", 16'h0, {12'h0, qout});
	endtask
	task automatic close_out;
		if (fails == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		wt(20);
		rst <= 1'b0;
		t_stopped();
		t_setup();
		t_start();
		close_out();
	end
endmodule // testbench
`default_nettype wire
